// *** rtl/esd_pkg.sv ***
// Function
// - read-only copy of serial one FIFO control
// - bit0: line2 mgmt interrupt on both edges
// - bit1: line6 mgmt interrupt on both edges
// - bit2: line2 wake event on both edges
// - bit3: line6 wake event on both edges
// - disable bits 7:5 and 3 override peripheral activate bits
// - disable register writable only when unlocked, pin allows
// - bit0 set forces floppy write protected
// - write protect is OR of four terms
// - lock bit freezes register until main/PCI reset
// - disable register bit2 reads zero
// - bit3 disables the floppy controller
// - bit5 disables serial port two
// - bit6 disables serial port one
// - bit7 disables the parallel port
// - disabled peripheral ignores host and SMBus accesses
`default_nettype none
package esd_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] ESD_IDX_FCR_COPY   = 8'h20;
	localparam logic [7:0] ESD_IDX_EDGE_SEL   = 8'h21;
	localparam logic [7:0] ESD_IDX_DISABLE    = 8'h22;
	// reset values
	localparam logic [7:0] ESD_RST_FCR_COPY   = 8'h00;
	localparam logic [7:0] ESD_RST_EDGE_SEL   = 8'h00;
	localparam logic [7:0] ESD_RST_DISABLE    = 8'h00;
	// readable bits of each register
	localparam logic [7:0] ESD_MASK_FCR_COPY  = 8'hCF;
	localparam logic [7:0] ESD_MASK_EDGE_SEL  = 8'h0F;
	localparam logic [7:0] ESD_MASK_DISABLE   = 8'hEB;
	// edge select field positions
	localparam int ESD_EDGE_L2_MGMT           = 0;
	localparam int ESD_EDGE_L6_MGMT           = 1;
	localparam int ESD_EDGE_L2_WAKE           = 2;
	localparam int ESD_EDGE_L6_WAKE           = 3;
	// disable register field positions
	localparam int ESD_DIS_WP_OVERRIDE        = 0;
	localparam int ESD_DIS_LOCK               = 1;
	// peripheral order: floppy, serial two, serial one, parallel
	localparam int ESD_NUM_PERIPH             = 4;
	localparam int ESD_DIS_POS [ESD_NUM_PERIPH] = '{3, 5, 6, 7};
	// lock pin configuration value that lets the pin lock the register
	localparam logic [1:0] ESD_LOCK_PIN_CFG   = 2'h1;
	// bus responses
	localparam logic [1:0] ESD_RESP_OKAY      = 2'h0;
	localparam logic [1:0] ESD_RESP_SLVERR    = 2'h2;
	// number of watched port lines
	localparam int ESD_NUM_LINES              = 2;
endpackage
`default_nettype wire

// *** rtl/esd_edge_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// carries port line levels, edge choices and status set pulses
interface esd_edge_if #(parameter int N = 2);
	logic [N-1:0] line_lvl;   // sampled port line levels
	logic [N-1:0] mgmt_both;  // 1: mgmt status on both edges
	logic [N-1:0] wake_both;  // 1: wake status on both edges
	logic [N-1:0] mgmt_set;   // one-cycle mgmt status set pulse
	logic [N-1:0] wake_set;   // one-cycle wake status set pulse
	// register side drives levels and choices
	modport ctl (
		output line_lvl,
		output mgmt_both,
		output wake_both,
		input  mgmt_set,
		input  wake_set
	);
	// detector side reports set pulses
	modport det (
		input  line_lvl,
		input  mgmt_both,
		input  wake_both,
		output mgmt_set,
		output wake_set
	);
endinterface
`default_nettype wire

// *** rtl/esd_edge_det.sv ***
`timescale 1ns/10ps
`default_nettype none
// per-line edge detector for mgmt interrupt and wake status
module esd_edge_det
	import esd_pkg::*;
#(
	parameter int N = 2
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	esd_edge_if.det   edge_io
);
	logic [N-1:0] prev_ff;   // line level one cycle ago
	logic         armed_ff;  // prev_ff holds a real sample

	// at least one line must be watched
	if (N < 1) begin : g_bad_n
		$error("esd_edge_det: N must be at least 1");
	end

	// arm after the first sample so reset level makes no edge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			armed_ff <= 1'b0;
		end else begin
			armed_ff <= 1'b1;
		end
	end

	// remember last level
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= edge_io.line_lvl;
		end
	end

	// one generate slice per watched line
	for (genvar g = 0; g < N; g++) begin : g_line
		logic fall;  // high-to-low transition
		logic rise;  // low-to-high transition
		logic mgmt_set_ff;
		logic wake_set_ff;
		assign fall = armed_ff & prev_ff[g] & ~edge_io.line_lvl[g];
		assign rise = armed_ff & ~prev_ff[g] & edge_io.line_lvl[g];
		// falling edge always counts, rising only in both-edge mode
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				mgmt_set_ff <= 1'b0;
				wake_set_ff <= 1'b0;
			end else begin
				mgmt_set_ff <= fall | (rise & edge_io.mgmt_both[g]);
				wake_set_ff <= fall | (rise & edge_io.wake_both[g]);
			end
		end
		assign edge_io.mgmt_set[g] = mgmt_set_ff;
		assign edge_io.wake_set[g] = wake_set_ff;
	end
endmodule
`default_nettype wire

// *** rtl/esd_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// edge select and peripheral disable register bank, AXI4-Lite slave
module esd_regs
	import esd_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_b,
	// extra reset sources, synchronous, active high
	input  wire logic                      main_por,
	input  wire logic                      pci_reset,
	input  wire logic                      standby_power_on_reset,
	// AXI4-Lite slave
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// serial one FIFO control writes, copied into the shadow
	input  wire logic                      ser1_fcr_wr,
	input  wire logic [7:0]                ser1_fcr_data,
	// keyboard controller port lines
	input  wire logic                      kbc_port1_line2,
	input  wire logic                      kbc_port1_line6,
	output logic [ESD_NUM_LINES-1:0]       mgmt_interrupt_set,
	output logic [ESD_NUM_LINES-1:0]       wake_event_set,
	// lock pin and its configuration field
	input  wire logic                      lock_control_pin,
	input  wire logic [1:0]                lock_pin_cfg,
	// floppy write protect terms
	input  wire logic                      write_protect_n,
	input  wire logic                      drive_sel_zero_n,
	input  wire logic                      drive_sel_one_n,
	input  wire logic                      force_write_protect,
	output logic                           floppy_wp_to_core,
	// peripherals: floppy, serial two, serial one, parallel
	input  wire logic [ESD_NUM_PERIPH-1:0] periph_activate,
	input  wire logic [ESD_NUM_PERIPH-1:0] lpc_access_req,
	input  wire logic [ESD_NUM_PERIPH-1:0] smb_access_req,
	output logic [ESD_NUM_PERIPH-1:0]      periph_enable,
	output logic [ESD_NUM_PERIPH-1:0]      lpc_access_grant,
	output logic [ESD_NUM_PERIPH-1:0]      smb_access_grant
);
	localparam int WW = ADDR_W - 2;  // word index width

	// the highest index needs eight address bits
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
		$error("esd_regs: ADDR_W must be 8 to 32");
	end

	// ---------------- bus state ----------------
	logic              awready_ff;   // address channel open
	logic              wready_ff;    // data channel open
	logic              aw_full_ff;   // address held, waiting for data
	logic              w_full_ff;    // data held, waiting for address
	logic [ADDR_W-1:0] awaddr_ff;    // held write address
	logic [7:0]        wdata_ff;     // held write byte
	logic              wstrb0_ff;    // held lane 0 strobe
	logic              bvalid_ff;    // write response pending
	logic [1:0]        bresp_ff;     // write response code
	logic              arready_ff;   // read address channel open
	logic              rvalid_ff;    // read data pending
	logic [31:0]       rdata_ff;     // read data word
	logic [1:0]        rresp_ff;     // read response code

	// ---------------- register state ----------------
	logic [7:0]        fcr_copy_ff;  // serial one FIFO control copy
	logic [7:0]        edge_sel_ff;  // edge select
	logic [7:0]        disable_ff;   // peripheral disable
	logic              wp_ff;        // write protect to floppy core
	logic [ESD_NUM_PERIPH-1:0] enable_ff;
	logic [ESD_NUM_PERIPH-1:0] lpc_grant_ff;
	logic [ESD_NUM_PERIPH-1:0] smb_grant_ff;

	// ---------------- write path decode ----------------
	logic              aw_take;      // address taken this edge
	logic              w_take;       // data taken this edge
	logic              do_wr;        // both halves present, commit
	logic [ADDR_W-1:0] wr_addr;      // address of committing write
	logic [7:0]        wr_byte;      // byte of committing write
	logic              wr_lane0;     // lane 0 enabled
	logic [WW-1:0]     wr_word;      // word index of write
	logic              wr_hit_fcr;   // write hits shadow
	logic              wr_hit_edge;  // write hits edge select
	logic              wr_hit_dis;   // write hits disable register
	logic              dis_writable; // disable register may change
	logic              nxt_aw_full;
	logic              nxt_w_full;
	logic              nxt_bvalid;

	assign aw_take  = s_axi_awvalid & awready_ff;
	assign w_take   = s_axi_wvalid & wready_ff;
	assign wr_addr  = aw_take ? s_axi_awaddr : awaddr_ff;
	assign wr_byte  = w_take ? s_axi_wdata[7:0] : wdata_ff;
	assign wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb0_ff;
	assign wr_word  = wr_addr[ADDR_W-1:2];
	assign do_wr    = (aw_full_ff | aw_take) & (w_full_ff | w_take) & ~bvalid_ff;

	assign wr_hit_fcr  = (wr_word == WW'(ESD_IDX_FCR_COPY));
	assign wr_hit_edge = (wr_word == WW'(ESD_IDX_EDGE_SEL));
	assign wr_hit_dis  = (wr_word == WW'(ESD_IDX_DISABLE));

	// locked by the lock bit, or by the pin when so configured
	assign dis_writable = ~disable_ff[ESD_DIS_LOCK] &
		~((lock_pin_cfg == ESD_LOCK_PIN_CFG) & lock_control_pin);

	assign nxt_aw_full = (aw_full_ff | aw_take) & ~do_wr;
	assign nxt_w_full  = (w_full_ff | w_take) & ~do_wr;
	assign nxt_bvalid  = do_wr | (bvalid_ff & ~s_axi_bready);

	// write channel handshake; channels close while a response waits
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
		end else begin
			awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
			aw_full_ff <= nxt_aw_full;
			w_full_ff  <= nxt_w_full;
			bvalid_ff  <= nxt_bvalid;
		end
	end

	// hold whichever half arrived first
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			awaddr_ff <= '0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else begin
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff  <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
		end
	end

	// write response: unmapped addresses answer SLVERR
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bresp_ff <= ESD_RESP_OKAY;
		end else if (do_wr) begin
			if (wr_hit_fcr | wr_hit_edge | wr_hit_dis) begin
				bresp_ff <= ESD_RESP_OKAY;
			end else begin
				bresp_ff <= ESD_RESP_SLVERR;
			end
		end
	end

	// ---------------- registers ----------------

	// shadow follows serial one FIFO control writes, bus cannot write it
	always_ff @(posedge ref_clk) begin
		if (!rst_b || main_por || pci_reset || standby_power_on_reset) begin
			fcr_copy_ff <= ESD_RST_FCR_COPY;
		end else if (ser1_fcr_wr) begin
			fcr_copy_ff <= ser1_fcr_data & ESD_MASK_FCR_COPY;
		end
	end

	// edge select, only low four bits stored
	always_ff @(posedge ref_clk) begin
		if (!rst_b || standby_power_on_reset) begin
			edge_sel_ff <= ESD_RST_EDGE_SEL;
		end else if (do_wr && wr_hit_edge && wr_lane0) begin
			edge_sel_ff <= wr_byte & ESD_MASK_EDGE_SEL;
		end
	end

	// disable register; lock cleared by main and PCI resets
	always_ff @(posedge ref_clk) begin
		if (!rst_b || standby_power_on_reset) begin
			disable_ff <= ESD_RST_DISABLE;
		end else begin
			if (do_wr && wr_hit_dis && wr_lane0 && dis_writable) begin
				disable_ff <= wr_byte & ESD_MASK_DISABLE;
			end
			if (main_por || pci_reset) begin
				disable_ff[ESD_DIS_LOCK] <= 1'b0;
			end
		end
	end

	// ---------------- read path ----------------
	logic          ar_take;   // read address taken
	logic [WW-1:0] rd_word;   // word index of read
	logic          nxt_rvalid;

	assign ar_take    = s_axi_arvalid & arready_ff;
	assign rd_word    = s_axi_araddr[ADDR_W-1:2];
	assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

	// read handshake, one read at a time
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	// read data captured with the address; reserved bits read zero
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= ESD_RESP_OKAY;
		end else if (ar_take) begin
			rresp_ff <= ESD_RESP_OKAY;
			if (rd_word == WW'(ESD_IDX_FCR_COPY)) begin
				rdata_ff <= {24'h00_0000, fcr_copy_ff};
			end else if (rd_word == WW'(ESD_IDX_EDGE_SEL)) begin
				rdata_ff <= {24'h00_0000, edge_sel_ff & ESD_MASK_EDGE_SEL};
			end else if (rd_word == WW'(ESD_IDX_DISABLE)) begin
				rdata_ff <= {24'h00_0000, disable_ff & ESD_MASK_DISABLE};
			end else begin
				rdata_ff <= 32'h0000_0000;
				rresp_ff <= ESD_RESP_SLVERR;
			end
		end
	end

	// ---------------- edge detection ----------------
	esd_edge_if #(.N(ESD_NUM_LINES)) edge_bus ();

	// line 2 on slot 0, line 6 on slot 1
	assign edge_bus.line_lvl  = {kbc_port1_line6, kbc_port1_line2};
	assign edge_bus.mgmt_both = {edge_sel_ff[ESD_EDGE_L6_MGMT], edge_sel_ff[ESD_EDGE_L2_MGMT]};
	assign edge_bus.wake_both = {edge_sel_ff[ESD_EDGE_L6_WAKE], edge_sel_ff[ESD_EDGE_L2_WAKE]};

	esd_edge_det #(
		.N       (ESD_NUM_LINES)
	) u_edge_det (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.edge_io (edge_bus.det)
	);

	// ---------------- floppy write protect ----------------

	// override OR drive input OR forced per selected drive
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wp_ff <= 1'b0;
		end else begin
			wp_ff <= disable_ff[ESD_DIS_WP_OVERRIDE] |
				write_protect_n |
				(drive_sel_zero_n & force_write_protect) |
				(drive_sel_one_n & force_write_protect);
		end
	end

	// ---------------- peripheral enables and access gating ----------------
	for (genvar g = 0; g < ESD_NUM_PERIPH; g++) begin : g_periph
		logic dis;  // this peripheral forced off
		assign dis = disable_ff[ESD_DIS_POS[g]];
		// disable overrides activate; accesses dropped while off
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				enable_ff[g]    <= 1'b0;
				lpc_grant_ff[g] <= 1'b0;
				smb_grant_ff[g] <= 1'b0;
			end else begin
				enable_ff[g]    <= periph_activate[g] & ~dis;
				lpc_grant_ff[g] <= lpc_access_req[g] & ~dis;
				smb_grant_ff[g] <= smb_access_req[g] & ~dis;
			end
		end
	end

	// ---------------- outputs ----------------
	assign s_axi_awready      = awready_ff;
	assign s_axi_wready       = wready_ff;
	assign s_axi_bvalid       = bvalid_ff;
	assign s_axi_bresp        = bresp_ff;
	assign s_axi_arready      = arready_ff;
	assign s_axi_rvalid       = rvalid_ff;
	assign s_axi_rdata        = rdata_ff;
	assign s_axi_rresp        = rresp_ff;
	assign mgmt_interrupt_set = edge_bus.mgmt_set;
	assign wake_event_set     = edge_bus.wake_set;
	assign floppy_wp_to_core  = wp_ff;
	assign periph_enable      = enable_ff;
	assign lpc_access_grant   = lpc_grant_ff;
	assign smb_access_grant   = smb_grant_ff;
endmodule
`default_nettype wire

// *** verification/esd_regs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the register bank: bus timing, gating and edge pulses
module esd_regs_asserts (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        kbc_port1_line2,
	input wire logic        kbc_port1_line6,
	input wire logic [1:0]  mgmt_interrupt_set,
	input wire logic [1:0]  wake_event_set,
	input wire logic        write_protect_n,
	input wire logic        drive_sel_zero_n,
	input wire logic        drive_sel_one_n,
	input wire logic        force_write_protect,
	input wire logic        floppy_wp_to_core,
	input wire logic [3:0]  periph_activate,
	input wire logic [3:0]  lpc_access_req,
	input wire logic [3:0]  periph_enable,
	input wire logic [3:0]  lpc_access_grant
);
	// one clock domain, one reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// full write taken in one edge is answered on the next
	a_write_resp_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	// response stands until accepted
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	a_read_resp_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	// bit 4 is unused in every register, upper lanes unused
	a_rdata_zero_bits: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4])
		else $error("reserved read bits set");
	// any active protect term forces protection one cycle later
	a_wp_terms: assert property (write_protect_n || (force_write_protect && (drive_sel_zero_n || drive_sel_one_n))
		|=> floppy_wp_to_core)
		else $error("write protect term lost");
	// a peripheral is never enabled without its activate bit
	a_enable_gated: assert property ((periph_enable & ~$past(periph_activate)) == 4'h0)
		else $error("enable without activate");
	// host grant follows the same disable as the enable
	a_grant_match: assert property ((($past(periph_activate) & $past(lpc_access_req)) & (periph_enable ^ lpc_access_grant)) == 4'h0)
		else $error("grant differs from enable");
	// a status pulse needs a recent line change
	a_line2_cause: assert property (mgmt_interrupt_set[0] |-> $past(kbc_port1_line2, 1) != $past(kbc_port1_line2, 4))
		else $error("line2 pulse without edge");
	a_line6_cause: assert property (wake_event_set[1] |-> $past(kbc_port1_line6, 1) != $past(kbc_port1_line6, 4))
		else $error("line6 pulse without edge");
	// main scenarios reached
	c_write_done: cover property (s_axi_bvalid && s_axi_bready);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
	c_mgmt_pulse: cover property (mgmt_interrupt_set[0]);
	c_wp_forced: cover property (floppy_wp_to_core && !write_protect_n);
endmodule
bind esd_regs esd_regs_asserts u_esd_chk (.*);
`default_nettype wire

// *** verification/esd_regs_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// directed test of the register bank through its AXI4-Lite port
module esd_regs_test
	import esd_pkg::*;
();
	localparam logic [9:0] A_SH = {ESD_IDX_FCR_COPY, 2'b00};  // shadow word
	localparam logic [9:0] A_ES = {ESD_IDX_EDGE_SEL, 2'b00};  // edge select word
	localparam logic [9:0] A_DD = {ESD_IDX_DISABLE, 2'b00};   // disable word
	logic ref_clk = 1'b0, rst_b = 1'b0, main_por = 1'b0, pci_reset = 1'b0, standby_power_on_reset = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;        // protection ignored
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;                              // full word writes
	logic [1:0] s_axi_bresp, s_axi_rresp, mgmt_interrupt_set, wake_event_set;
	logic [1:0] lock_pin_cfg = 2'h0;
	logic ser1_fcr_wr = 1'b0, kbc_port1_line2 = 1'b1, kbc_port1_line6 = 1'b1, lock_control_pin = 1'b0;
	logic [7:0] ser1_fcr_data = 8'hFF;
	logic write_protect_n = 1'b0, drive_sel_zero_n = 1'b0, drive_sel_one_n = 1'b0, force_write_protect = 1'b0;
	logic floppy_wp_to_core;
	logic [3:0] periph_activate = 4'hF, lpc_access_req = 4'hF, smb_access_req = 4'hF;
	logic [3:0] periph_enable, lpc_access_grant, smb_access_grant;
	int fail_count = 0, cmp_count = 0;
	int mg_cnt[2] = '{0, 0}, wk_cnt[2] = '{0, 0};               // status pulses seen per line
	logic [7:0] es_tab[3] = '{8'h00, 8'hF5, 8'h0A};             // edge choices tried

	esd_regs uut (.*);

	// free running clock
	always #5 ref_clk = ~ref_clk;

	// count status pulses per line
	always @(posedge ref_clk) begin
		if (rst_b) begin
			for (int k = 0; k < 2; k++) begin
				mg_cnt[k] += mgmt_interrupt_set[k];
				wk_cnt[k] += wake_event_set[k];
			end
		end
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// a wait that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 50) begin
			fail_count++;
			$display("Error at %0t: bus wait ran out", $time);
			end_of_test();
		end
	endtask

	// bus write; upper data lanes carry junk that must be ignored
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge ref_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {24'hA5A5A5, d};
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(n);
		chk(s_axi_bresp, r);
	endtask

	// bus read with expected data and response
	task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		tmo(n);
		chk(s_axi_rdata, {24'h0, d});
		chk(s_axi_rresp, r);
	endtask

	// one-cycle pulse: 0 fifo write, 1 main, 2 pci, 3 standby reset
	task automatic pulse(input int k);
		@(posedge ref_clk);
		{standby_power_on_reset, pci_reset, main_por, ser1_fcr_wr} <= 4'h1 << k;
		@(posedge ref_clk);
		{standby_power_on_reset, pci_reset, main_por, ser1_fcr_wr} <= 4'h0;
	endtask

	// move one port line and count the pulses it causes
	task automatic tog(input int ln, input logic v, input int em, input int ew);
		int m;
		int w;
		m = mg_cnt[ln];
		w = wk_cnt[ln];
		@(posedge ref_clk);
		if (ln == 0) kbc_port1_line2 <= v;
		else kbc_port1_line6 <= v;
		repeat (8) @(posedge ref_clk);
		chk(mg_cnt[ln] - m, em);
		chk(wk_cnt[ln] - w, ew);
	endtask

	initial begin
		logic [3:0] b;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(A_SH, 8'h00, ESD_RESP_OKAY);
		rd(A_ES, 8'h00, ESD_RESP_OKAY);
		rd(A_DD, 8'h00, ESD_RESP_OKAY);
		// shadow copies the fifo control write, ignores the bus, clears on pci reset
		pulse(0);
		rd(A_SH, 8'hCF, ESD_RESP_OKAY);
		wr(A_SH, 8'h00, ESD_RESP_OKAY);
		rd(A_SH, 8'hCF, ESD_RESP_OKAY);
		pulse(2);
		rd(A_SH, 8'h00, ESD_RESP_OKAY);
		// unmapped word is refused
		wr(10'h08C, 8'hFF, ESD_RESP_SLVERR);
		rd(10'h08C, 8'h00, ESD_RESP_SLVERR);
		// falling edges always count, rising only where chosen
		foreach (es_tab[k]) begin
			wr(A_ES, es_tab[k], ESD_RESP_OKAY);
			rd(A_ES, es_tab[k] & ESD_MASK_EDGE_SEL, ESD_RESP_OKAY);
			for (int i = 0; i < 2; i++) begin
				tog(i, 1'b0, 1, 1);
				tog(i, 1'b1, es_tab[k][i], es_tab[k][i+2]);
			end
		end
		// each disable bit blocks just its peripheral
		for (int i = 0; i < ESD_NUM_PERIPH; i++) begin
			wr(A_DD, 8'h01 << ESD_DIS_POS[i], ESD_RESP_OKAY);
			repeat (2) @(posedge ref_clk);
			b = 4'hF & ~(4'h1 << i);
			chk(periph_enable, b);
			chk(lpc_access_grant, b);
			chk(smb_access_grant, b);
		end
		// everything set: lock holds, override protects
		wr(A_DD, 8'hFF, ESD_RESP_OKAY);
		wr(A_DD, 8'h00, ESD_RESP_OKAY);
		rd(A_DD, 8'hEB, ESD_RESP_OKAY);
		chk(floppy_wp_to_core, 1'b1);
		chk(periph_enable, 4'h0);
		pulse(1);
		rd(A_DD, 8'hE9, ESD_RESP_OKAY);
		wr(A_DD, 8'h00, ESD_RESP_OKAY);
		// every combination of the protect terms
		for (int i = 0; i < 16; i++) begin
			b = i[3:0];
			write_protect_n <= b[0];
			drive_sel_zero_n <= b[1];
			drive_sel_one_n <= b[2];
			force_write_protect <= b[3];
			repeat (2) @(posedge ref_clk);
			chk(floppy_wp_to_core, b[0] | (b[3] & (b[1] | b[2])));
		end
		// lock pin blocks writes only when configured and high
		wr(A_DD, 8'h01, ESD_RESP_OKAY);
		lock_pin_cfg <= ESD_LOCK_PIN_CFG;
		lock_control_pin <= 1'b1;
		wr(A_DD, 8'h20, ESD_RESP_OKAY);
		rd(A_DD, 8'h01, ESD_RESP_OKAY);
		lock_pin_cfg <= 2'h2;
		wr(A_DD, 8'h20, ESD_RESP_OKAY);
		rd(A_DD, 8'h20, ESD_RESP_OKAY);
		lock_pin_cfg <= ESD_LOCK_PIN_CFG;
		lock_control_pin <= 1'b0;
		wr(A_DD, 8'h42, ESD_RESP_OKAY);
		// pci reset frees the lock only
		pulse(2);
		rd(A_DD, 8'h40, ESD_RESP_OKAY);
		// standby reset clears both registers
		wr(A_ES, 8'h0F, ESD_RESP_OKAY);
		pulse(3);
		rd(A_ES, 8'h00, ESD_RESP_OKAY);
		rd(A_DD, 8'h00, ESD_RESP_OKAY);
		// enables and grants follow activate and request where not disabled
		periph_activate <= 4'h5;
		lpc_access_req <= 4'h6;
		smb_access_req <= 4'h9;
		wr(A_DD, 8'h08, ESD_RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk(periph_enable, 4'h4);
		chk(lpc_access_grant, 4'h6);
		chk(smb_access_grant, 4'h8);
		end_of_test();
	end
endmodule
`default_nettype wire
